// File: emb_bus_ctrl.v
// external memory bus controller with apb control register
`timescale 1ns/1ps
`default_nettype none
`include "emb_map.vh"
module emb_bus_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire data_width_cfg,
  input wire [1:0] addr_width_cfg,
  input wire wait_enable_cfg,
  input wire small_package,
  input wire sleep_mode,
  input wire exec_external,
  input wire acc_req,
  input wire acc_write,
  input wire [20:0] acc_addr,
  input wire [7:0] table_latch,
  input wire table_latch_wr,
  input wire [15:0] ad_in,
  output reg acc_done,
  output reg [15:0] acc_rdata,
  output reg [15:0] ad_out,
  output reg [15:0] ad_oe,
  output reg [3:0] addr_hi,
  output reg [3:0] addr_hi_oe,
  output reg [7:0] ctl_out,
  output reg ctl_own,
  output reg [2:0] pin_own
);
  // phases of one external access
  localparam PH_IDLE = 3'd0;
  localparam PH_ADDR = 3'd1;
  localparam PH_DATA = 3'd2;
  localparam PH_WAIT = 3'd3;
  localparam PH_END = 3'd4;

  // wait code to cycle count: 11->0 ... 00->3
  function [1:0] wait_cycles;
    input [1:0] code;
    begin
      wait_cycles = ~code;
    end
  endfunction

  // --------------------------------------------------------------
  // control register
  // --------------------------------------------------------------
  reg [7:0] external_bus_control;
  reg dis_eff; // handover of bus_disable delayed while running external
  reg [2:0] phase;
  reg [1:0] wcnt;
  reg [15:0] wdata;
  reg wr_hi, wr_lo;
  wire bus_off = (addr_width_cfg == `EMB_ABW_MCU) | small_package;
  wire bus_disable = external_bus_control[`EMB_BIT_DIS];
  wire wide = data_width_cfg;
  wire [1:0] word_write_select = external_bus_control[1:0];
  wire apb_wr = psel & penable & pwrite & pready;
  wire [7:0] ctrl_rd = bus_off ? 8'h00 : external_bus_control;

  // apb register write; no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_bus_control <= `EMB_CTRL_RESET;
    end else if (apb_wr && paddr == `EMB_REG_CTRL && !bus_off) begin
      external_bus_control <= pwdata[7:0] & `EMB_CTRL_MASK;
    end
  end

  // apb answer: ready in the access phase, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= (paddr != `EMB_REG_CTRL) && (paddr != `EMB_REG_STAT);
      if (paddr == `EMB_REG_CTRL)
        prdata <= {24'h000000, ctrl_rd};
      else if (paddr == `EMB_REG_STAT)
        prdata <= {24'h000000, bus_off, dis_eff, 3'h0, phase};
      else
        prdata <= 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // setting bus_disable takes effect only while executing internally; clearing takes effect at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_eff <= 1'b0;
    end else if (!exec_external) begin
      dis_eff <= bus_disable;
    end else if (!bus_disable) begin
      dis_eff <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // access sequencer
  // --------------------------------------------------------------
  // write data and strobe selection per write mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata <= 16'h0000;
      wr_hi <= 1'b0;
      wr_lo <= 1'b0;
    end else if (phase == PH_IDLE && acc_req && !acc_done) begin
      if (!wide) begin
        wdata <= {table_latch, table_latch};
        wr_hi <= 1'b0;
        wr_lo <= 1'b1;
      end else if (word_write_select[1]) begin
        wdata <= {table_latch, wdata[7:0]};
        wr_hi <= table_latch_wr;
        wr_lo <= 1'b0;
      end else if (word_write_select == `EMB_WM_BSEL) begin
        wdata <= {table_latch, table_latch};
        wr_hi <= 1'b1;
        wr_lo <= 1'b0;
      end else begin
        wdata <= {table_latch, table_latch};
        wr_hi <= acc_addr[0];
        wr_lo <= ~acc_addr[0];
      end
    end else if (phase == PH_IDLE && !word_write_select[1] == 1'b0 &&
                 table_latch_wr) begin
      wdata <= {wdata[15:8], table_latch}; // low byte held for word write
    end
  end

  // phase machine: address, data, wait, end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
      wcnt <= 2'b00;
    end else begin
      case (phase)
        PH_IDLE: begin
          // a request still up in the done cycle is the old one
          if (acc_req && !acc_done && !bus_off && !sleep_mode)
            phase <= PH_ADDR;
        end
        PH_ADDR: phase <= PH_DATA;
        PH_DATA: begin
          wcnt <= wait_cycles(external_bus_control[5:4]);
          if (wait_enable_cfg && wait_cycles(external_bus_control[5:4])
              != 2'b00)
            phase <= PH_WAIT;
          else
            phase <= PH_END;
        end
        PH_WAIT: begin
          wcnt <= wcnt - 2'b01;
          if (wcnt == 2'b01)
            phase <= PH_END;
        end
        PH_END: phase <= PH_IDLE;
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  wire active = (phase != PH_IDLE);
  wire data_ph = (phase == PH_DATA) || (phase == PH_WAIT);
  wire hold_bus = !dis_eff || active;
  wire [2:0] used = (addr_width_cfg == `EMB_ABW_20) ? 3'b111 :
                    (addr_width_cfg == `EMB_ABW_16) ? 3'b011 :
                    (addr_width_cfg == `EMB_ABW_12) ? 3'b011 : 3'b000;

  // pins are registered; idle bus floats ad and parks strobes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ad_out <= 16'h0000;
      ad_oe <= 16'h0000;
      addr_hi <= 4'h0;
      addr_hi_oe <= 4'h0;
      ctl_out <= `EMB_CTL_IDLE;
      ctl_own <= 1'b0;
      pin_own <= 3'b000;
      acc_done <= 1'b0;
      acc_rdata <= 16'h0000;
    end else begin
      acc_done <= (phase == PH_END);
      ctl_own <= !bus_off && hold_bus;
      pin_own <= (!bus_off && hold_bus) ? used : 3'b000;
      ctl_out <= `EMB_CTL_IDLE;
      ad_oe <= 16'h0000;
      addr_hi_oe <= 4'h0;
      if (active) begin
        addr_hi <= acc_addr[20:17];
        addr_hi_oe <= used[2] ? 4'hf : 4'h0;
        ctl_out[`EMB_CB_CE] <= sleep_mode;
        ctl_out[`EMB_CB_BA0] <= acc_addr[0];
        if (phase == PH_ADDR) begin
          ad_out <= acc_addr[16:1];
          ad_oe <= 16'hffff;
          ctl_out[`EMB_CB_ALE] <= 1'b1;
        end else if (data_ph && acc_write) begin
          ad_out <= wdata;
          ad_oe <= wide ? 16'hffff : 16'h00ff;
          ctl_out[`EMB_CB_WRH] <= ~(wide & wr_hi);
          ctl_out[`EMB_CB_WRL] <= ~(wr_lo | (wide & ~wr_hi & ~wr_lo));
          if (wide && word_write_select == `EMB_WM_BSEL) begin
            ctl_out[`EMB_CB_UB] <= acc_addr[0] ? 1'b1 : 1'b0;
            ctl_out[`EMB_CB_LB] <= acc_addr[0] ? 1'b0 : 1'b1;
          end else begin
            ctl_out[`EMB_CB_UB] <= 1'b0;
            ctl_out[`EMB_CB_LB] <= 1'b0;
          end
        end else if (data_ph) begin
          ctl_out[`EMB_CB_OE] <= 1'b0;
          ctl_out[`EMB_CB_UB] <= 1'b0;
          ctl_out[`EMB_CB_LB] <= 1'b0;
        end else if (phase == PH_END && !acc_write) begin
          acc_rdata <= wide ? ad_in : {8'h00, ad_in[7:0]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: emb_bus_ctrl_properties.sv
// assertion checker for the external memory bus controller
`timescale 1ns/1ps
`default_nettype none
`include "emb_map.vh"
module emb_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [1:0] addr_width_cfg,
  input wire logic sleep_mode,
  input wire logic acc_req,
  input wire logic acc_done,
  input wire logic [3:0] addr_hi_oe,
  input wire logic [7:0] ctl_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answers without wait states, ready stands one cycle
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  // strobes idle when no access is pending
  property p_idle; !acc_req [*3] |-> ctl_out == `EMB_CTL_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("strobes not idle");
  property p_ce; acc_done |-> !$past(ctl_out[`EMB_CB_CE]); endproperty
  a_ce: assert property (p_ce) else $error("chip enable off");
  property p_slp; sleep_mode [*2] |-> ctl_out[`EMB_CB_CE]; endproperty
  a_slp: assert property (p_slp) else $error("ce low in sleep");
  property p_hi; addr_hi_oe != 0 |-> addr_width_cfg == `EMB_ABW_20;
  endproperty
  a_hi: assert property (p_hi) else $error("upper lines driven");
  property p_off; addr_width_cfg == `EMB_ABW_MCU [*2]
    |-> addr_hi_oe == 0 && ctl_out == `EMB_CTL_IDLE; endproperty
  a_off: assert property (p_off) else $error("bus off but active");
  property p_wait; $rose(acc_req) |-> ##[1:12] acc_done; endproperty
  a_wait: assert property (p_wait) else $error("access hung");
  c_acc: cover property (acc_done);
  c_apb: cover property (pready);
  c_hi: cover property (addr_hi_oe != 0);
endmodule
bind emb_bus_ctrl emb_props u_props (.pclk, .presetn, .psel, .penable,
  .pready, .addr_width_cfg, .sleep_mode, .acc_req, .acc_done,
  .addr_hi_oe, .ctl_out);
`default_nettype wire

// File: emb_map.vh
// register map, field layout, configuration codes and timing for the bus block
//
// Contract
// - 28 pins: three address/data ports (20 lines) plus one control port.
// - 8 or 16 bit data; 12, 16 or 20 bit address.
// - lines 0-7 first port, 8-15 second, 16-19 low nibble of third.
// - control port bits 0..7: latch, oe, wrl, wrh, ba0, ce, lb, ub.
// - microcontroller-only mode: control register disabled, writes ignored.
// - bus_disable clear: bus owns its pins permanently.
// - bus_disable set: pins are ports except during external accesses.
// - bus_disable resets to zero, bus enabled.
// - wait code 11,10,01,00 adds 0,1,2,3 cycles to table accesses.
// - write mode field ignored in 8-bit data width.
// - mode 1x: word write from latch, high strobe on latch write.
// - mode 01: byte on both halves, high strobe with ub or lb.
// - mode 00: byte on both halves, high or low strobe picks byte.
// - widths come only from configuration inputs, not software.
// - data width bit set (default) means 16-bit data.
// - address width field: 20, 16, 12 bit or bus disabled.
// - unused upper lines become dedicated ports (12-bit mode keeps lines 12-15 on the bus); code 01 is 16-bit.
// - address and data share lines; memory latches address first.
// - register bits 6 and 3-2 ignore writes and read zero.
// - small package: bus absent, register reads zero.
// - wait cycles only when the wait enable configuration bit is set.
// - disable set from external code waits for an internal branch.
// - idle enabled bus: ad floats, active-low strobes high, ale/ba0 low.
// - chip enable low each access, high during sleep.
`ifndef EMB_MAP_VH
`define EMB_MAP_VH
`define EMB_REG_CTRL 12'h000
`define EMB_REG_STAT 12'h004
`define EMB_CTRL_RESET 8'h00
`define EMB_CTRL_MASK 8'hb3
`define EMB_BIT_DIS 7
`define EMB_ABW_20 2'b00
`define EMB_ABW_16 2'b01
`define EMB_ABW_12 2'b10
`define EMB_ABW_MCU 2'b11
`define EMB_WM_BSEL 2'b01
`define EMB_WM_BWR 2'b00
`define EMB_CB_ALE 0
`define EMB_CB_OE 1
`define EMB_CB_WRL 2
`define EMB_CB_WRH 3
`define EMB_CB_BA0 4
`define EMB_CB_CE 5
`define EMB_CB_LB 6
`define EMB_CB_UB 7
`define EMB_CTL_IDLE 8'hee
`define EMB_PH_WAIT_W 2
`endif

// File: emb_mem_model.sv
// behavioural external memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module emb_mem (
  input wire logic pclk,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  input wire logic [7:0] ctl_out,
  output logic [15:0] ad_in
);
  logic [15:0] mem [0:255];
  logic [7:0] adr;
  logic [15:0] last = 16'h0;
  logic [15:0] drv;
  initial for (int i = 0; i < 256; i++) mem[i] = {~i[7:0], i[7:0]};
  // released lines show a changing pattern, never the old value
  assign drv = (!ctl_out[1] && !ctl_out[5]) ? mem[adr] : ~last;
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & drv);
  // address taken while latch strobe high, ahead of data
  always @(posedge pclk) begin
    last <= drv;
    if (ctl_out[0]) adr <= ad_out[7:0];
    if (!ctl_out[5] && !ctl_out[2]) mem[adr][7:0] <= ad_out[7:0];
    if (!ctl_out[5] && !ctl_out[3]) mem[adr][15:8] <= ad_out[15:8];
  end
endmodule
`default_nettype wire

// File: test_external_memory_bus_control.sv
// self-checking bench for the external memory bus controller
`timescale 1ns/1ps
`default_nettype none
`include "emb_map.vh"
`define CHK(n, e, g) comparisons++; \
  if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end
module test_external_memory_bus_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic data_width_cfg = 1, wait_enable_cfg = 1, small_package = 0;
  logic sleep_mode = 0, exec_external = 0, acc_req = 0, acc_write = 0;
  logic table_latch_wr = 0, pready, pslverr, acc_done, ctl_own;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'h2518;
  logic [1:0] addr_width_cfg = 0;
  logic [20:0] acc_addr = 0;
  logic [7:0] table_latch = 0, ctl_out;
  logic [15:0] ad_in, acc_rdata, ad_out, ad_oe;
  logic [3:0] addr_hi, addr_hi_oe;
  logic [2:0] pin_own;
  logic [32:0] q[$], ex;
  int err_total = 0, comparisons = 0, n, lat[4];
  emb_bus_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .data_width_cfg, .addr_width_cfg,
    .wait_enable_cfg, .small_package, .sleep_mode, .exec_external,
    .acc_req, .acc_write, .acc_addr, .table_latch, .table_latch_wr, .ad_in,
    .acc_done, .acc_rdata, .ad_out, .ad_oe, .addr_hi, .addr_hi_oe,
    .ctl_out, .ctl_own, .pin_own);
  emb_mem i_mem (.pclk, .ad_out, .ad_oe, .ctl_out, .ad_in);
  initial forever #12.5 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // apb transfer held until ready is sampled
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  // memory access held until done, counting cycles
  task acc(input logic w, input logic [20:0] a, output int c);
    @(posedge pclk);
    acc_req <= 1;
    acc_write <= w;
    acc_addr <= a;
    c = 0;
    do begin @(posedge pclk); c++; end while (acc_done !== 1'b1);
    acc_req <= 0;
  endtask
  task end_sim;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // results compared in order against the noted expectations
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      ex = q.pop_front();
      `CHK("apb read", ex, {pslverr, pslverr ? 32'h0 : prdata})
    end
    if (acc_done && !acc_write) begin
      ex = q.pop_front();
      `CHK("bus read", ex, {17'h0, acc_rdata})
    end
  end
  initial begin
    #200us;
    err_total++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    q.push_back(33'h0);
    apb(`EMB_REG_CTRL, 0, 0);
    `CHK("own", 4'hf, {ctl_own, pin_own})
    apb(`EMB_REG_CTRL, 1, 32'hff);
    q.push_back(33'hb3);
    apb(`EMB_REG_CTRL, 0, 0);
    q.push_back({1'b1, 32'h0});
    apb(12'h008, 0, 0);
    for (int c = 0; c < 4; c++) begin
      apb(`EMB_REG_CTRL, 1, c << 4);
      seed = xs(seed);
      q.push_back({~seed[8:1], seed[8:1]});
      acc(0, seed[20:0], lat[c]);
    end
    for (int c = 0; c < 3; c++) begin
      `CHK("wait", 3 - c, lat[c] - lat[3])
    end
    apb(`EMB_REG_CTRL, 1, 0);
    wait_enable_cfg <= 0;
    seed = xs(seed);
    table_latch <= seed[31:24];
    acc(1, {seed[20:1], 1'b1}, n);
    q.push_back({seed[31:24], seed[8:1]});
    acc(0, {seed[20:1], 1'b1}, n);
    `CHK("no wait", lat[3], n)
    addr_width_cfg <= `EMB_ABW_16;
    q.push_back({~seed[16:9], seed[16:9]});
    acc(0, {12'h0, seed[16:9], 1'b0}, n);
    `CHK("own16", 4'hb, {ctl_own, pin_own})
    apb(`EMB_REG_CTRL, 1, 32'hb0);
    repeat (3) @(posedge pclk);
    `CHK("own off", 4'h0, {ctl_own, pin_own})
    apb(`EMB_REG_CTRL, 1, 32'h30);
    addr_width_cfg <= `EMB_ABW_MCU;
    apb(`EMB_REG_CTRL, 1, 32'h80);
    addr_width_cfg <= `EMB_ABW_20;
    q.push_back(33'h30);
    apb(`EMB_REG_CTRL, 0, 0);
    small_package <= 1;
    q.push_back(33'h0);
    apb(`EMB_REG_CTRL, 0, 0);
    sleep_mode <= 1;
    repeat (4) @(posedge pclk);
    sleep_mode <= 0;
    end_sim;
  end
endmodule
`default_nettype wire
